// ==== core/dtc_timer.sv ====
// timer pair with mode, clock select, carrier output and apb register file
// assumes a single 100 mhz clock and an apb master with 32-bit data
`timescale 1ns/1ns
`include "dtc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - timer a control resets to zero
// - timer a run bit clears/stops or starts
// - timer a clock: /64, /256, b match, carrier
// - three-bit mode code selects four modes
// - cascade ignores timer a run bit
// - timer b run clears/starts both in cascade
// - cascade forces timer a clock as b clock
// - timer b clock: 1,4,2,4,8,16 divide
// - output gate selects port or timer
// - carrier control resets to zero
// - active one: carrier or steady high
// - active zero: output low, carrier halted
// - timer a match loads next into active
// - active bit writable only while gate off
// - next bit lost on carrier stop
// - low width from b compare, high from h compare
module dtc_timer #(
   parameter int DIV_A0 = `DTC_DIV_A_SLOW,
   parameter int DIV_A1 = `DTC_DIV_A_SLOWER
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        portLatch,
   output logic             timerOutputPin,
   output logic             timerAMatch,
   output logic             timerBMatch
);
   logic [7:0]  tmaCtrl_ff;
   logic [7:0]  tmbCtrl_ff;
   logic [2:0]  cocCtrl_ff;
   logic [7:0]  taCmp_ff;
   logic [7:0]  tbCmp_ff;
   logic [7:0]  tbHCmp_ff;
   logic [7:0]  taCnt_ff;
   logic [7:0]  tbCnt_ff;
   logic [7:0]  preA_ff;
   logic [3:0]  preB_ff;
   logic        tbLevel_ff;
   logic        prevAMatch_ff;
   logic        carrierRun_ff;
   logic        wrEn;
   logic        rdEn;
   logic        hit;
   logic [15:0] idx;
   logic [2:0]  modeCode;
   dtc_pkg::dtc_mode_t mode;
   logic        runA;
   logic        runB;
   logic        tickB;
   logic        tickA;
   logic        aEq;
   logic        bEq;
   logic        bHEq;
   logic        aMatch;
   logic        bMatch;
   logic        carrierMode;
   logic        nxt_out;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   assign idx  = paddr[17:2];
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && !penable && !pwrite;
   always_comb
   begin
      hit = 1'b1;
      unique case (idx)
         `DTC_IDX_TMA, `DTC_IDX_TMB, `DTC_IDX_COC, `DTC_IDX_TACMP,
         `DTC_IDX_TBCMP, `DTC_IDX_TBHCMP, `DTC_IDX_TACNT, `DTC_IDX_TBCNT: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (rdEn)
      begin
         unique case (idx)
            `DTC_IDX_TMA:    prdata <= {24'h00_0000, tmaCtrl_ff};
            `DTC_IDX_TMB:    prdata <= {24'h00_0000, tmbCtrl_ff};
            `DTC_IDX_COC:    prdata <= {29'h0000_0000, cocCtrl_ff};
            `DTC_IDX_TACMP:  prdata <= {24'h00_0000, taCmp_ff};
            `DTC_IDX_TBCMP:  prdata <= {24'h00_0000, tbCmp_ff};
            `DTC_IDX_TBHCMP: prdata <= {24'h00_0000, tbHCmp_ff};
            `DTC_IDX_TACNT:  prdata <= {24'h00_0000, taCnt_ff};
            `DTC_IDX_TBCNT:  prdata <= {24'h00_0000, tbCnt_ff};
            default:         prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers; unused bits held at zero
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmaCtrl_ff <= `DTC_RST_CTRL;
         tmbCtrl_ff <= `DTC_RST_CTRL;
      end
      else if (wrEn)
      begin
         if (idx == `DTC_IDX_TMA)
            tmaCtrl_ff <= pwdata[7:0] & `DTC_TA_MASK;
         if (idx == `DTC_IDX_TMB)
            tmbCtrl_ff <= pwdata[7:0] & `DTC_TB_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         taCmp_ff  <= 8'h00;
         tbCmp_ff  <= 8'h00;
         tbHCmp_ff <= 8'h00;
      end
      else if (wrEn)
      begin
         if (idx == `DTC_IDX_TACMP)
            taCmp_ff <= pwdata[7:0];
         if (idx == `DTC_IDX_TBCMP)
            tbCmp_ff <= pwdata[7:0];
         if (idx == `DTC_IDX_TBHCMP)
            tbHCmp_ff <= pwdata[7:0];
      end
   end

   // hardware load of the active bit wins over a software write
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         cocCtrl_ff <= 3'h0;
      else
      begin
         if (wrEn && idx == `DTC_IDX_COC)
         begin
            cocCtrl_ff[`DTC_COC_REMOTE] <= pwdata[`DTC_COC_REMOTE];
            cocCtrl_ff[`DTC_COC_NEXT]   <= pwdata[`DTC_COC_NEXT];
            if (!tmbCtrl_ff[`DTC_TB_GATE_BIT])
               cocCtrl_ff[`DTC_COC_ACTIVE] <= pwdata[`DTC_COC_ACTIVE];
         end
         // only the stop edge drops it, so a reload made while stopped survives
         else if (carrierRun_ff && !(carrierMode && runB))
            cocCtrl_ff[`DTC_COC_NEXT] <= 1'b0;
         if (aMatch && !prevAMatch_ff)
            cocCtrl_ff[`DTC_COC_ACTIVE] <= cocCtrl_ff[`DTC_COC_NEXT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode decode
   assign modeCode = {tmaCtrl_ff[`DTC_TA_MODE_BIT], tmbCtrl_ff[2:1]};
   always_comb
   begin
      unique case (modeCode)
         `DTC_MODE_CASCADE: mode = dtc_pkg::DTC_CASCADE;
         `DTC_MODE_CARRIER: mode = dtc_pkg::DTC_CARRIER;
         `DTC_MODE_PWM:     mode = dtc_pkg::DTC_PWM;
         default:           mode = dtc_pkg::DTC_DISCRETE; // prohibited codes fall back
      endcase
   end
   assign carrierMode = (mode == dtc_pkg::DTC_CARRIER);
   assign runB = tmbCtrl_ff[`DTC_RUN_BIT];
   assign runA = (mode == dtc_pkg::DTC_CASCADE) ? runB : tmaCtrl_ff[`DTC_RUN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // prescalers and clock selects
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         preA_ff <= 8'h00;
         preB_ff <= 4'h0;
      end
      else
      begin
         preA_ff <= preA_ff + 8'h01;
         preB_ff <= preB_ff + 4'h1;
      end
   end

   always_comb
   begin
      unique case (tmbCtrl_ff[5:3])
         3'h0:    tickB = 1'b1;
         3'h1:    tickB = preB_ff[1:0] == 2'h3;
         3'h2:    tickB = preB_ff[0];
         3'h3:    tickB = preB_ff[1:0] == 2'h3;
         3'h4:    tickB = preB_ff[2:0] == 3'h7;
         3'h5:    tickB = preB_ff == 4'hf;
         default: tickB = 1'b0; // prohibited codes hold the counter
      endcase
   end

   // in cascade timer a counts the b clock and b counts a's overflow
   always_comb
   begin
      if (mode == dtc_pkg::DTC_CASCADE)
         tickA = tickB;
      else
      begin
         unique case (tmaCtrl_ff[4:3])
            // divides are powers of two up to 256, so a mask finds the wrap
            2'h0: tickA = (preA_ff & 8'(DIV_A0 - 1)) == 8'(DIV_A0 - 1);
            2'h1: tickA = (preA_ff & 8'(DIV_A1 - 1)) == 8'(DIV_A1 - 1);
            2'h2: tickA = bMatch && tickB;
            2'h3: tickA = bMatch && tickB && tbLevel_ff;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counters
   assign aEq  = taCnt_ff == taCmp_ff;
   assign bEq  = tbCnt_ff == tbCmp_ff;
   assign bHEq = tbCnt_ff == tbHCmp_ff;
   always_comb
   begin
      if (mode == dtc_pkg::DTC_CASCADE)
      begin
         aMatch = aEq && bEq;
         bMatch = aMatch;
      end
      else
      begin
         aMatch = aEq && runA;
         bMatch = runB && ((carrierMode || mode == dtc_pkg::DTC_PWM) ?
                           (tbLevel_ff ? bHEq : bEq) : bEq);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         taCnt_ff <= 8'h00;
      else if (!runA)
         taCnt_ff <= 8'h00;
      else if (tickA)
         taCnt_ff <= aMatch ? 8'h00 : taCnt_ff + 8'h01;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         tbCnt_ff <= 8'h00;
      else if (!runB)
         tbCnt_ff <= 8'h00;
      else if (mode == dtc_pkg::DTC_CASCADE)
      begin
         if (tickB && aMatch)
            tbCnt_ff <= 8'h00;
         else if (tickB && taCnt_ff == 8'hff)
            tbCnt_ff <= tbCnt_ff + 8'h01;
      end
      else if (tickB)
         tbCnt_ff <= bMatch ? 8'h00 : tbCnt_ff + 8'h01;
   end

   // b output level toggles on each b match; cleared when stopped or when carrier mode has the active bit at zero
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         tbLevel_ff <= 1'b0;
      else if (!runB || (carrierMode && !cocCtrl_ff[`DTC_COC_ACTIVE]))
         tbLevel_ff <= 1'b0;
      else if (tickB && bMatch)
         tbLevel_ff <= !tbLevel_ff;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prevAMatch_ff <= 1'b0;
         carrierRun_ff <= 1'b0;
         timerAMatch   <= 1'b0;
         timerBMatch   <= 1'b0;
      end
      else
      begin
         prevAMatch_ff <= aMatch;
         carrierRun_ff <= carrierMode && runB;
         timerAMatch   <= aMatch && tickA;
         timerBMatch   <= bMatch && tickB;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output pin
   always_comb
   begin
      if (!tmbCtrl_ff[`DTC_TB_GATE_BIT])
         nxt_out = portLatch;
      else if (!carrierMode)
         nxt_out = tbLevel_ff;
      else if (!cocCtrl_ff[`DTC_COC_ACTIVE])
         nxt_out = 1'b0;
      else
         nxt_out = cocCtrl_ff[`DTC_COC_REMOTE] ? 1'b1 : tbLevel_ff;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         timerOutputPin <= 1'b0;
      else
         timerOutputPin <= nxt_out;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   stopA_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !runA |=> taCnt_ff == 8'h00) else $error("timer a not cleared when stopped");
   cascRun_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (mode == dtc_pkg::DTC_CASCADE && !runB) |=> taCnt_ff == 8'h00)
      else $error("cascade timer a ran without b enable");
   stopB_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !runB |=> tbCnt_ff == 8'h00) else $error("timer b not cleared when stopped");
   gateOff_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !tmbCtrl_ff[0] |=> timerOutputPin == $past(portLatch))
      else $error("pin not under port control");
   remoteHigh_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (tmbCtrl_ff[0] && carrierMode && cocCtrl_ff[0] && cocCtrl_ff[2]) |=> timerOutputPin)
      else $error("remote mode not high");
   activeLow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (tmbCtrl_ff[0] && carrierMode && !cocCtrl_ff[0]) |=> !timerOutputPin)
      else $error("output not low with active zero");
   reload_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (aMatch && !prevAMatch_ff) |=> cocCtrl_ff[0] == $past(cocCtrl_ff[1]))
      else $error("active bit not reloaded");
   lockActive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (tmbCtrl_ff[0] && !(aMatch && !prevAMatch_ff)) |=> $stable(cocCtrl_ff[0]))
      else $error("active bit changed while gated");
   slave_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (psel && !penable) |=> pready) else $error("apb answer late");
   cascCov_c: cover property (@(posedge sys_clk) mode == dtc_pkg::DTC_CASCADE && tickB);
   carrCov_c: cover property (@(posedge sys_clk) carrierMode && aMatch && tmbCtrl_ff[0]);
   pwmCov_c: cover property (@(posedge sys_clk) mode == dtc_pkg::DTC_PWM && bMatch);
endmodule // dtc_timer

// ==== inc/dtc_defines.svh ====
// register offsets, field positions, reset values and mode codes
// assumes apb byte addressing; each register sits in one aligned word
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
`define DTC_IDX_TMA        16'hff65
`define DTC_IDX_TMB        16'hff69
`define DTC_IDX_COC        16'hff6a
`define DTC_IDX_TACMP      16'h0100
`define DTC_IDX_TBCMP      16'h0101
`define DTC_IDX_TBHCMP     16'h0102
`define DTC_IDX_TACNT      16'h0103
`define DTC_IDX_TBCNT      16'h0104
`define DTC_RST_CTRL       8'h00
`define DTC_RUN_BIT        7
`define DTC_TA_CLK_LO      3
`define DTC_TA_MODE_BIT    1
`define DTC_TB_CLK_LO      3
`define DTC_TB_MODE_LO     1
`define DTC_TB_GATE_BIT    0
`define DTC_COC_REMOTE     2
`define DTC_COC_NEXT       1
`define DTC_COC_ACTIVE     0
`define DTC_TA_MASK        8'h9a
`define DTC_TB_MASK        8'hbf
`define DTC_COC_MASK       8'h07
`define DTC_MODE_DISCRETE  3'h0
`define DTC_MODE_CASCADE   3'h5
`define DTC_MODE_CARRIER   3'h3
`define DTC_MODE_PWM       3'h2
`define DTC_DIV_A_SLOW     64
`define DTC_DIV_A_SLOWER   256
`endif

// ==== inc/dtc_pkg.sv ====
// types shared by the timer pair
// assumes nothing beyond the defines header
package dtc_pkg;
   typedef enum logic [1:0] {DTC_DISCRETE, DTC_CASCADE, DTC_CARRIER, DTC_PWM} dtc_mode_t;
endpackage

// ==== verification/dtc_pin_model.sv ====
// far-side model: a transmitter input watching the timer pin, plus the port latch
// assumes the pin is registered on sys_clk and the latch is set by the bench
`timescale 1ns/1ns
module dtc_pin_model (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        pinIn,
   input  wire logic        latchReq,
   output logic             portLatch,
   output logic [15:0]      edgeCount
);
   logic        latch_ff;
   logic        pinLast_ff;
   logic [15:0] edge_ff;
   ////////////////////////////////////////////////////////////////////////////////
   // latch lags the request a cycle, like a port write
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         latch_ff   <= 1'h0;
         pinLast_ff <= 1'h0;
         edge_ff    <= 16'h0000;
      end
      else
      begin
         latch_ff   <= latchReq;
         pinLast_ff <= pinIn;
         // counts only, no decoding: carrier shape is the bench's business
         if (pinIn != pinLast_ff)
            edge_ff <= edge_ff + 16'h0001;
      end
   end
   assign portLatch = latch_ff;
   assign edgeCount = edge_ff;
endmodule // dtc_pin_model

// ==== verification/dual_8bit_timer_control_tb.sv ====
// self-checking bench for the timer pair: apb master, scoreboard queue, pin model
// assumes the timer core, its defines header and the pin model are compiled first
`timescale 1ns/1ns
`include "dtc_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %0t: got %h exp %h", $time, g, e); end end
module dual_8bit_timer_control_tb;
   localparam int DA0 = 4;
   localparam int DA1 = 8;
   logic        sys_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, latchReq = 1'h0, rdyS = 1'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic        pready, pslverr, portLatch, pin, aMatch, bMatch;
   logic [15:0] edges, e0;
   logic [32:0] expQ[$];
   logic [32:0] expNow;
   logic [7:0]  rv;
   int          n_errors = 0, n_checks = 0, seed = 6886, per;
   int          bper[6] = '{2, 8, 4, 8, 16, 32};
   int          aper[3] = '{4 * DA0, 4 * DA1, 8};
   dtc_timer #(.DIV_A0(DA0), .DIV_A1(DA1)) dtc_timer_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .portLatch(portLatch),
      .timerOutputPin(pin), .timerAMatch(aMatch), .timerBMatch(bMatch));
   dtc_pin_model dtc_pin_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .pinIn(pin),
      .latchReq(latchReq), .portLatch(portLatch), .edgeCount(edges));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end
   // mid-cycle sampling keeps the compare clear of edge races
   always @(negedge sys_clk)
   begin
      rdyS = pready;
      if (psel && penable && pready && !pwrite)
      begin
         if (expQ.size() == 0) `CHK(1'h1, 1'h0)
         else
         begin
            expNow = expQ.pop_front();
            `CHK({pslverr, prdata}, expNow)
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
      input logic [32:0] ex);
      int n;
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {14'h0000, idx, 2'h0};
      pwdata <= {24'h000000, d};
      if (!wr) expQ.push_back(ex);
      @(posedge sys_clk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (rdyS !== 1'h1 && n < 50);
      if (rdyS !== 1'h1) n_errors++;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      apb(1'h1, i, d, 33'h0);
   endtask
   task automatic rd(input logic [15:0] i, input logic [7:0] e);
      apb(1'h0, i, 8'h00, {25'h0, e});
   endtask
   // first match syncs, second gives the period
   task automatic period(input logic a, output int c);
      int g;
      g = 0;
      do @(negedge sys_clk); while ((a ? aMatch : bMatch) !== 1'h1 && ++g < 2000);
      c = 0;
      do
      begin
         @(negedge sys_clk);
         c++;
      end
      while ((a ? aMatch : bMatch) !== 1'h1 && c < 2000);
      if (c >= 2000 || g >= 2000) n_errors++;
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #800000;
      n_errors++;
      end_sim;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'h1;
      rd(`DTC_IDX_TMA, 8'h00);
      rd(`DTC_IDX_COC, 8'h00);
      apb(1'h0, 16'h0200, 8'h00, {1'h1, 32'h0});
      repeat (4)
      begin
         rv = 8'($random(seed));
         // unused bits, run bits and clock codes 6/7 kept clear
         wr(`DTC_IDX_TMA, rv & 8'h1a);
         rd(`DTC_IDX_TMA, rv & 8'h1a);
         wr(`DTC_IDX_TMB, rv & 8'h2e);
         rd(`DTC_IDX_TMB, rv & 8'h2e);
      end
      wr(`DTC_IDX_TMA, 8'h00);
      wr(`DTC_IDX_TACMP, 8'h03);
      wr(`DTC_IDX_TBCMP, 8'h01);
      wr(`DTC_IDX_TBHCMP, 8'h01);
      for (int k = 0; k < 6; k++)
      begin
         wr(`DTC_IDX_TMB, 8'h00);
         wr(`DTC_IDX_TMB, {2'h2, 3'(k), 3'h0});
         period(1'h0, per);
         `CHK(per, bper[k])
      end
      wr(`DTC_IDX_TMB, 8'h80);
      for (int k = 0; k < 3; k++)
      begin
         wr(`DTC_IDX_TMA, 8'h00);
         wr(`DTC_IDX_TMA, {3'h4, 2'(k), 3'h0});
         period(1'h1, per);
         `CHK(per, aper[k])
      end
      wr(`DTC_IDX_TMA, 8'h00);
      repeat (40) @(posedge sys_clk);
      rd(`DTC_IDX_TACNT, 8'h00);
      // cascade: timer a run bit alone must not count
      wr(`DTC_IDX_TMB, 8'h02);
      wr(`DTC_IDX_TMA, 8'h82);
      repeat (40) @(posedge sys_clk);
      rd(`DTC_IDX_TACNT, 8'h00);
      wr(`DTC_IDX_TMB, 8'h82);
      repeat (300) @(posedge sys_clk);
      wr(`DTC_IDX_TMB, 8'h02);
      rd(`DTC_IDX_TACNT, 8'h00);
      rd(`DTC_IDX_TBCNT, 8'h00);
      wr(`DTC_IDX_TMA, 8'h00);
      wr(`DTC_IDX_TMB, 8'h86);
      for (int k = 1; k >= 0; k--)
      begin
         latchReq <= 1'(k);
         repeat (4) @(negedge sys_clk);
         `CHK(pin, 1'(k))
      end
      wr(`DTC_IDX_COC, 8'h06);
      wr(`DTC_IDX_TMB, 8'h87);
      repeat (3) @(negedge sys_clk);
      `CHK(pin, 1'h0)
      wr(`DTC_IDX_TMA, 8'h80);
      period(1'h1, per);
      repeat (3) @(negedge sys_clk);
      `CHK(pin, 1'h1)
      wr(`DTC_IDX_COC, 8'h04);
      rd(`DTC_IDX_COC, 8'h05);
      period(1'h1, per);
      repeat (3) @(negedge sys_clk);
      `CHK(pin, 1'h0)
      wr(`DTC_IDX_COC, 8'h02);
      period(1'h1, per);
      e0 = edges;
      repeat (12) @(negedge sys_clk);
      `CHK(edges != e0, 1'h1)
      wr(`DTC_IDX_TMA, 8'h00);
      wr(`DTC_IDX_TMB, 8'h85);
      e0 = edges;
      repeat (12) @(negedge sys_clk);
      `CHK(edges != e0, 1'h1)
      // a stop drops the buffered bit; a reload made while stopped survives
      wr(`DTC_IDX_TMB, 8'h86);
      wr(`DTC_IDX_COC, 8'h03);
      wr(`DTC_IDX_TMB, 8'h06);
      repeat (4) @(posedge sys_clk);
      rd(`DTC_IDX_COC, 8'h01);
      wr(`DTC_IDX_COC, 8'h03);
      wr(`DTC_IDX_TMB, 8'h86);
      repeat (4) @(posedge sys_clk);
      rd(`DTC_IDX_COC, 8'h03);
      repeat (4) @(posedge sys_clk);
      end_sim;
   end
endmodule // dual_8bit_timer_control_tb
